// [hw/shcg_pkg.sv]
// constants shared by the sync header parity generator
package shcg_pkg;
    // block and multiblock geometry
    localparam int unsigned BLK_BITS    = 64;
    localparam int unsigned MB_BLOCKS   = 32;
    localparam int unsigned CNT_W       = 5;
    localparam logic [4:0]  LAST_BLOCK  = 5'h1F;
    localparam logic [4:0]  FIRST_BLOCK = 5'h00;
    localparam int unsigned EMB_W       = 8;
    localparam logic [7:0]  EMB_DEFAULT = 8'h01;

    // parity generators
    localparam int unsigned CRC_W    = 12;
    // feedback taps below x^12: x^9+x^8+x^3+x^2+x+1; the short form 0x987
    // keeps x^12 and drops the constant term, so it cannot feed the taps
    localparam logic [11:0] CRC_POLY = 12'h30F;
    localparam int unsigned FEC_W    = 26;
    localparam logic [25:0] FEC_POLY = 26'h0220211;

    // mode selection codes
    localparam logic [1:0] MODE_CRC12 = 2'h0;
    localparam logic [1:0] MODE_CRC3  = 2'h1;
    localparam logic [1:0] MODE_FEC   = 2'h2;

    // stream layout
    localparam int unsigned STREAM_W    = 32;
    localparam int unsigned PILOT_LSB   = 27;
    localparam logic [4:0]  PILOT_VALUE = 5'h10;
    localparam int unsigned EXT_MULTIBLOCK_END_FLAG_BIT   = 22;
    localparam int unsigned CRC_GROUPS  = 4;
    localparam int unsigned CRC_GRP_W   = 3;
    localparam int unsigned FEC_HI_BITS = 22;
    localparam int unsigned FEC_LO_LSB  = 23;
    localparam int unsigned FEC_LO_BITS = 4;

    // sync header pair, element [1] goes on the line first
    localparam logic [1:0] SH_ONE  = 2'h1;
    localparam logic [1:0] SH_ZERO = 2'h2;
endpackage

// [hw/shcg_par_lfsr.sv]
// serial-equivalent parity shift register, one data word per step
`timescale 1ns/100ps
`default_nettype none
module shcg_par_lfsr #(
    parameter int unsigned W    = 12,
    parameter logic [W-1:0] POLY = 12'h30F,
    parameter int unsigned DW   = 64
) (
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    input  wire logic          i_step,
    input  wire logic          i_restart,
    input  wire logic [DW-1:0] i_data,
    output logic      [W-1:0]  o_par_next
);
    logic [W-1:0] state_reg;
    logic [W-1:0] seed;

    // msb of the word is the first bit on the line
    function automatic logic [W-1:0] shcg_step(input logic [W-1:0] s_in,
                                               input logic [DW-1:0] d);
        logic [W-1:0] s;
        logic         fb;
        s = s_in;
        for (int i = DW - 1; i >= 0; i--) begin
            fb = d[i] ^ s[W-1];
            s  = {s[W-2:0], 1'b0};
            if (fb) begin
                s = s ^ POLY;
            end
        end
        return s;
    endfunction

    // first block of a multiblock starts from an all-zero register
    assign seed       = i_restart ? '0 : state_reg;
    assign o_par_next = shcg_step(seed, i_data);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else if (i_step) begin
            state_reg <= o_par_next;
        end
    end
endmodule
`default_nettype wire

// [hw/shcg_gen.sv]
// transmit sync header stream generator with crc-12 and fec parity
`timescale 1ns/100ps
`default_nettype none
module shcg_gen #(
    parameter int unsigned EMB_W = shcg_pkg::EMB_W
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic [1:0]                    i_sync_header_mode_sel,
    input  wire logic [EMB_W-1:0]              i_emb_len,
    input  wire logic                          i_mb_restart,
    input  wire logic                          i_blk_valid,
    input  wire logic [shcg_pkg::BLK_BITS-1:0] i_blk_data,
    output logic                               o_blk_valid,
    output logic [shcg_pkg::BLK_BITS-1:0]      o_blk_data,
    output logic [1:0]                         o_sync_header,
    output logic                               o_mb_first,
    output logic                               o_ext_multiblock_end_flag,
    output logic [shcg_pkg::STREAM_W-1:0]      o_stream_word,
    output logic                               o_mode_invalid
);
    logic [shcg_pkg::CNT_W-1:0]    cnt_reg;
    logic [shcg_pkg::CNT_W-1:0]    cur_cnt;
    logic [EMB_W-1:0]              emb_cnt_reg;
    logic [EMB_W-1:0]              cur_emb;
    logic [EMB_W-1:0]              emb_last_idx;
    logic                          ext_multiblock_end_flag;
    logic                          mb_start;
    logic                          mb_end;
    logic                          mode_fec_reg;
    logic [shcg_pkg::CRC_W-1:0]    crc_next;
    logic [shcg_pkg::FEC_W-1:0]    fec_next;
    logic [shcg_pkg::CRC_W-1:0]    crc_hold_reg;
    logic [shcg_pkg::FEC_W-1:0]    fec_hold_reg;
    logic [shcg_pkg::STREAM_W-1:0] stream;
    logic                          stream_bit;
    logic                          sel_fec;

    // a restart pulse makes the block of this cycle block 0 of a new extended multiblock
    assign cur_cnt  = i_mb_restart ? shcg_pkg::FIRST_BLOCK : cnt_reg;
    assign cur_emb  = i_mb_restart ? '0 : emb_cnt_reg;
    assign mb_start = i_blk_valid && (cur_cnt == shcg_pkg::FIRST_BLOCK);
    assign mb_end   = i_blk_valid && (cur_cnt == shcg_pkg::LAST_BLOCK);

    // length zero is taken as one multiblock per extended multiblock
    assign emb_last_idx = (i_emb_len == '0) ? '0 : EMB_W'(i_emb_len - 1'b1);
    assign ext_multiblock_end_flag        = (cur_emb == emb_last_idx);

    // crc-3 and the unused code fall back to crc-12, flagged to software
    assign sel_fec = (i_sync_header_mode_sel == shcg_pkg::MODE_FEC);

    // crc-12 generator over the scrambled payload only
    shcg_par_lfsr #(
        .W    (shcg_pkg::CRC_W),
        .POLY (shcg_pkg::CRC_POLY),
        .DW   (shcg_pkg::BLK_BITS)
    ) u_crc (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_step     (i_blk_valid),
        .i_restart  (mb_start),
        .i_data     (i_blk_data),
        .o_par_next (crc_next)
    );

    // fire code generator, same framing
    shcg_par_lfsr #(
        .W    (shcg_pkg::FEC_W),
        .POLY (shcg_pkg::FEC_POLY),
        .DW   (shcg_pkg::BLK_BITS)
    ) u_fec (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_step     (i_blk_valid),
        .i_restart  (mb_start),
        .i_data     (i_blk_data),
        .o_par_next (fec_next)
    );

    // stream word for the multiblock in flight
    function automatic logic [shcg_pkg::STREAM_W-1:0] shcg_build(
        input logic                       fec,
        input logic [shcg_pkg::CRC_W-1:0] crc,
        input logic [shcg_pkg::FEC_W-1:0] par,
        input logic                       eo);
        logic [shcg_pkg::STREAM_W-1:0] s;
        s = '0;
        if (fec) begin
            for (int i = 0; i < shcg_pkg::FEC_HI_BITS; i++) begin
                s[i] = par[shcg_pkg::FEC_W - 1 - i];
            end
            for (int j = 0; j < shcg_pkg::FEC_LO_BITS; j++) begin
                s[shcg_pkg::FEC_LO_LSB + j] = par[shcg_pkg::FEC_LO_BITS - 1 - j];
            end
        end else begin
            // every fourth bit is a one so the pilot cannot form early
            for (int g = 0; g < shcg_pkg::CRC_GROUPS; g++) begin
                for (int j = 0; j < shcg_pkg::CRC_GRP_W; j++) begin
                    s[4*g + j] = crc[shcg_pkg::CRC_W - 1 - 3*g - j];
                end
                s[4*g + 3] = 1'b1;
            end
            s[19] = 1'b1;
            s[21] = 1'b1;
            s[23] = 1'b1;
            // command positions 16,17,18,20,24,25,26 stay zero
        end
        s[shcg_pkg::EXT_MULTIBLOCK_END_FLAG_BIT] = eo;
        s[shcg_pkg::STREAM_W-1 -: 5] = shcg_pkg::PILOT_VALUE;
        return s;
    endfunction

    // mode and parity are frozen per multiblock, so a mode change mid-way
    // cannot mix two layouts inside one stream word
    assign stream     = shcg_build(mode_fec_reg, crc_hold_reg, fec_hold_reg, ext_multiblock_end_flag);
    assign stream_bit = stream[cur_cnt];

    // block and extended multiblock counters
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= shcg_pkg::FIRST_BLOCK;
        end else if (i_blk_valid) begin
            cnt_reg <= shcg_pkg::CNT_W'(cur_cnt + 1'b1);
        end else if (i_mb_restart) begin
            cnt_reg <= shcg_pkg::FIRST_BLOCK;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            emb_cnt_reg <= '0;
        end else if (mb_end) begin
            emb_cnt_reg <= ext_multiblock_end_flag ? '0 : EMB_W'(cur_emb + 1'b1);
        end else if (i_mb_restart) begin
            emb_cnt_reg <= '0;
        end
    end

    // parity of the finished multiblock rides in the next one
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_hold_reg <= '0;
            fec_hold_reg <= '0;
            mode_fec_reg <= 1'b0;
        end else if (mb_end) begin
            crc_hold_reg <= crc_next;
            fec_hold_reg <= fec_next;
            mode_fec_reg <= sel_fec;
        end
    end

    // outgoing block with its sync header
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_blk_valid   <= 1'b0;
            o_blk_data    <= '0;
            o_sync_header <= shcg_pkg::SH_ZERO;
            o_mb_first    <= 1'b0;
        end else begin
            o_blk_valid <= i_blk_valid;
            o_mb_first  <= mb_start;
            if (i_blk_valid) begin
                o_blk_data    <= i_blk_data;
                o_sync_header <= stream_bit ? shcg_pkg::SH_ONE : shcg_pkg::SH_ZERO;
            end
        end
    end

    // status copy of the stream word, caught on block 0
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_stream_word             <= '0;
            o_ext_multiblock_end_flag <= 1'b0;
        end else if (mb_start) begin
            o_stream_word             <= stream;
            o_ext_multiblock_end_flag <= ext_multiblock_end_flag;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mode_invalid <= 1'b0;
        end else begin
            o_mode_invalid <= (i_sync_header_mode_sel != shcg_pkg::MODE_CRC12)
                              && !sel_fec;
        end
    end

    // ---- assertions ----
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_mb_close;
        mb_end;
    endsequence

    sequence s_blk_taken;
        i_blk_valid;
    endsequence

    sequence s_mb_open;
        mb_start;
    endsequence

    // bit-reversed views of the fec fields for the layout check
    logic [shcg_pkg::FEC_HI_BITS-1:0] fec_hi_seen;
    logic [shcg_pkg::FEC_LO_BITS-1:0] fec_lo_seen;
    assign fec_hi_seen = {<<{stream[21:0]}};
    assign fec_lo_seen = {<<{stream[26:23]}};

    chk_pilot_tail: assert property (
        stream[31:27] == shcg_pkg::PILOT_VALUE)
        else $error("pilot tail is not 00001");

    chk_crc_ones: assert property (
        !mode_fec_reg |-> (stream[3] && stream[7] && stream[11] && stream[15]
                          && stream[19] && stream[21] && stream[23]))
        else $error("crc fixed ones missing");

    chk_cmd_zero: assert property (
        !mode_fec_reg |-> ({stream[16], stream[17], stream[18], stream[20],
                           stream[24], stream[25], stream[26]} == 7'h00))
        else $error("command bits not zero");

    chk_crc_map: assert property (
        !mode_fec_reg |-> ({stream[0], stream[1], stream[2], stream[4], stream[5],
                           stream[6], stream[8], stream[9], stream[10], stream[12],
                           stream[13], stream[14]} == crc_hold_reg))
        else $error("crc bits misplaced");

    chk_fec_map: assert property (
        mode_fec_reg |-> (fec_hi_seen == fec_hold_reg[25:4]
                          && fec_lo_seen == fec_hold_reg[3:0]))
        else $error("fec bits misplaced");

    chk_parity_carry: assert property (
        s_mb_close |=> (crc_hold_reg == $past(crc_next)
                        && fec_hold_reg == $past(fec_next)))
        else $error("parity not carried to next multiblock");

    chk_mode_latch: assert property (
        (s_mb_close and (i_sync_header_mode_sel == 2'h2)) |=> mode_fec_reg)
        else $error("fec mode not taken");

    chk_crc_default: assert property (
        (mb_end && i_sync_header_mode_sel == 2'h0) |=> !mode_fec_reg)
        else $error("crc mode not taken");

    chk_no_crc3: assert property (
        (i_sync_header_mode_sel == 2'h1) |=> (o_mode_invalid && !$past(sel_fec)))
        else $error("crc-3 code not refused");

    chk_sh_encode: assert property (
        i_blk_valid |=> (o_sync_header == ($past(stream_bit) ? 2'h1 : 2'h2)))
        else $error("sync header pair wrong");

    chk_ext_multiblock_end_flag_only: assert property (
        mb_start |-> (stream[22] == (cur_emb == emb_last_idx)))
        else $error("end of extended multiblock bit wrong");

    chk_block_wrap: assert property (
        (s_mb_close and !i_mb_restart) |=> (cnt_reg == 5'h00))
        else $error("block counter did not wrap");

    chk_first_after_close: assert property (
        (s_mb_close and !i_mb_restart) |=> (!i_blk_valid || mb_start))
        else $error("next block is not block 0");

    chk_sh_legal: assert property (
        o_sync_header == shcg_pkg::SH_ONE || o_sync_header == shcg_pkg::SH_ZERO)
        else $error("sync header pair is not 01 or 10");

    chk_pilot_line: assert property (
        (i_blk_valid && cur_cnt >= shcg_pkg::CNT_W'(shcg_pkg::PILOT_LSB))
        |=> (o_sync_header == (($past(cur_cnt) == shcg_pkg::LAST_BLOCK)
                               ? shcg_pkg::SH_ONE : shcg_pkg::SH_ZERO)))
        else $error("pilot tail not sent on the line");

    chk_data_pass: assert property (
        s_blk_taken |=> (o_blk_valid && o_blk_data == $past(i_blk_data)))
        else $error("block data not passed through");

    chk_valid_drop: assert property (
        !i_blk_valid |=> !o_blk_valid)
        else $error("output valid without input block");

    chk_first_mark: assert property (
        s_blk_taken |=> (o_mb_first == $past(mb_start)))
        else $error("first block marker wrong");

    chk_word_snap: assert property (
        s_mb_open |=> (o_stream_word == $past(stream)))
        else $error("stream word not caught on block 0");

    chk_flag_snap: assert property (
        s_mb_open |=> (o_ext_multiblock_end_flag == $past(ext_multiblock_end_flag)))
        else $error("end flag not caught on block 0");

    chk_restart_first: assert property (
        (i_mb_restart && i_blk_valid) |-> mb_start)
        else $error("restart block is not block 0");

    chk_emb_wrap: assert property (
        (s_mb_close and ext_multiblock_end_flag) |=> (emb_cnt_reg == '0))
        else $error("extended multiblock count did not wrap");

    chk_emb_step: assert property (
        (s_mb_close and !ext_multiblock_end_flag) |=> (emb_cnt_reg == EMB_W'($past(cur_emb) + 1'b1)))
        else $error("extended multiblock count did not advance");

    chk_mode_hold: assert property (
        !mb_end |=> (mode_fec_reg == $past(mode_fec_reg)))
        else $error("mode changed inside a multiblock");

    chk_hold_stable: assert property (
        !mb_end |=> ($stable(crc_hold_reg) && $stable(fec_hold_reg)))
        else $error("parity changed inside a multiblock");

    chk_count_step: assert property (
        (i_blk_valid && !mb_end) |=> (cnt_reg == shcg_pkg::CNT_W'($past(cur_cnt) + 1'b1)))
        else $error("block counter did not advance");

    chk_count_idle: assert property (
        (!i_blk_valid && !i_mb_restart) |=> $stable(cnt_reg))
        else $error("block counter moved without a block");

    chk_mode_ok: assert property (
        (i_sync_header_mode_sel == shcg_pkg::MODE_CRC12
         || i_sync_header_mode_sel == shcg_pkg::MODE_FEC) |=> !o_mode_invalid)
        else $error("legal mode flagged as refused");
endmodule
`default_nettype wire

// [tb/shcg_rx_model.sv]
// far-side link receiver model: header stream decode and parity recompute
`timescale 1ns/100ps
`default_nettype none
module shcg_rx_model (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_blk_valid,
    input  wire logic [shcg_pkg::BLK_BITS-1:0] i_blk_data,
    input  wire logic [1:0]                    i_sync_header,
    input  wire logic                          i_mb_first,
    output logic      [31:0]                   o_rx_word,
    output logic      [11:0]                   o_crc_prev,
    output logic      [25:0]                   o_fec_prev,
    output logic      [15:0]                   o_mb_count,
    output logic      [15:0]                   o_hdr_err
);
    logic [11:0] crc_s;
    logic [11:0] crc_fin;
    logic [25:0] fec_s;
    logic [25:0] fec_fin;
    logic [31:0] word_s;
    logic [4:0]  idx;
    logic        fb;

    // behavioural, so blocking updates of the running state are intended
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_s = 12'h000;
            crc_fin = 12'h000;
            fec_s = 26'h0000000;
            fec_fin = 26'h0000000;
            word_s = 32'h0000_0000;
            idx = 5'h00;
            o_rx_word <= 32'h0000_0000;
            o_crc_prev <= 12'h000;
            o_fec_prev <= 26'h0000000;
            o_mb_count <= 16'h0000;
            o_hdr_err <= 16'h0000;
        end else if (i_blk_valid) begin
            // framing follows the block 0 marker, so a stray pilot in fec mode is harmless
            if (i_mb_first) begin
                idx = shcg_pkg::FIRST_BLOCK;
                crc_s = 12'h000;
                fec_s = 26'h0000000;
                word_s = 32'h0000_0000;
            end
            if (i_sync_header === shcg_pkg::SH_ONE)
                word_s[idx] = 1'b1;
            else if (i_sync_header !== shcg_pkg::SH_ZERO)
                o_hdr_err <= o_hdr_err + 16'h0001;
            // header bits never enter the parity, only the 64 data bits
            for (int b = 63; b >= 0; b--) begin
                fb = i_blk_data[b] ^ crc_s[11];
                crc_s = {crc_s[10:0], 1'b0} ^ (fb ? shcg_pkg::CRC_POLY : 12'h000);
                fb = i_blk_data[b] ^ fec_s[25];
                fec_s = {fec_s[24:0], 1'b0} ^ (fb ? shcg_pkg::FEC_POLY : 26'h0000000);
            end
            if (idx == shcg_pkg::LAST_BLOCK) begin
                // parity of the previous multiblock goes out with this stream
                o_rx_word <= word_s;
                o_crc_prev <= crc_fin;
                o_fec_prev <= fec_fin;
                o_mb_count <= o_mb_count + 16'h0001;
                crc_fin = crc_s;
                fec_fin = fec_s;
            end
            idx = idx + 5'h01;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_shcg_gen.sv]
// self-checking bench for the sync header parity generator
`timescale 1ns/100ps
`default_nettype none
module tb_shcg_gen;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [1:0]  i_sync_header_mode_sel = shcg_pkg::MODE_CRC12;
    logic [7:0]  i_emb_len = 8'h03;
    logic        i_mb_restart = 1'b0;
    logic        i_blk_valid = 1'b0;
    logic [63:0] i_blk_data = 64'h0;
    logic        o_blk_valid;
    logic [63:0] o_blk_data;
    logic [1:0]  o_sync_header;
    logic        o_mb_first;
    logic        o_ext_multiblock_end_flag;
    logic [31:0] o_stream_word;
    logic        o_mode_invalid;
    logic [31:0] rx_word;
    logic [11:0] rx_crc;
    logic [25:0] rx_fec;
    logic [15:0] rx_cnt;
    logic [15:0] rx_err;
    logic [1:0]  mode_now = 2'h0;
    logic [1:0]  nxt_mode = 2'h0;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          mbn = 0;
    int          emb_idx = 0;

    shcg_gen shcg_gen_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_sync_header_mode_sel(i_sync_header_mode_sel), .i_emb_len(i_emb_len),
        .i_mb_restart(i_mb_restart), .i_blk_valid(i_blk_valid), .i_blk_data(i_blk_data),
        .o_blk_valid(o_blk_valid), .o_blk_data(o_blk_data), .o_sync_header(o_sync_header),
        .o_mb_first(o_mb_first), .o_ext_multiblock_end_flag(o_ext_multiblock_end_flag),
        .o_stream_word(o_stream_word), .o_mode_invalid(o_mode_invalid));

    shcg_rx_model shcg_rx_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_blk_valid(o_blk_valid), .i_blk_data(o_blk_data), .i_sync_header(o_sync_header),
        .i_mb_first(o_mb_first), .o_rx_word(rx_word), .o_crc_prev(rx_crc),
        .o_fec_prev(rx_fec), .o_mb_count(rx_cnt), .o_hdr_err(rx_err));

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] stream_exp(input logic fec_on, input logic [11:0] c,
            input logic [25:0] f, input logic eo);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (fec_on) begin
            for (int k = 0; k < 22; k++) w[k] = f[25 - k];
            for (int k = 0; k < 4; k++) w[23 + k] = f[3 - k];
        end else begin
            for (int g = 0; g < 4; g++) begin
                for (int j = 0; j < 3; j++) w[4 * g + j] = c[11 - 3 * g - j];
                w[4 * g + 3] = 1'b1;
            end
            w[19] = 1'b1;
            w[21] = 1'b1;
            w[23] = 1'b1;
        end
        w[22] = eo;
        w[31] = 1'b1;
        return w;
    endfunction

    // kind 0 all zero, 1 single one in the last data bit, 2 pattern
    task automatic run_mb(input logic [1:0] nxt, input int kind, input bit rst, input bit gap);
        nxt_mode = nxt;
        if (rst)
            emb_idx = 0;
        for (int k = 0; k < 32; k++) begin
            @(posedge i_mclk);
            #1;
            i_blk_valid = !(gap && k % 8 == 4);
            if (!i_blk_valid) begin
                @(posedge i_mclk);
                #1;
                i_blk_valid = 1'b1;
            end
            i_mb_restart = rst && k == 0;
            i_sync_header_mode_sel = nxt;
            i_blk_data = (kind == 2) ? 64'h9E37_79B9_7F4A_7C15 * (k + mbn + 1)
                                     : {63'h0, kind == 1 && k == 31};
        end
        @(posedge i_mclk);
        #1;
        i_blk_valid = 1'b0;
        i_mb_restart = 1'b0;
    endtask

    task automatic check_mb(input bit own, input logic [11:0] c, input logic [25:0] f);
        int          t;
        int          e;
        logic        eo;
        logic [31:0] exp;
        t = 0;
        while (rx_cnt !== 16'(mbn + 1) && t < 200) begin
            @(posedge i_mclk);
            #1;
            t++;
        end
        if (t >= 200) begin
            n_fail++;
            summarize();
        end
        e = (i_emb_len == 8'h00) ? 1 : int'(i_emb_len);
        eo = (emb_idx == e - 1);
        if (!own) begin
            c = rx_crc;
            f = rx_fec;
        end
        exp = stream_exp(mode_now == shcg_pkg::MODE_FEC, c, f, eo);
        check("rx stream", rx_word, exp);
        check("stream word", o_stream_word, exp);
        check("end flag", 32'(o_ext_multiblock_end_flag), 32'(eo));
        check("mode flag", 32'(o_mode_invalid), 32'(nxt_mode[0]));
        check("header errors", 32'(rx_err), 32'h0);
        check("data hi", o_blk_data[63:32], i_blk_data[63:32]);
        check("data lo", o_blk_data[31:0], i_blk_data[31:0]);
        check("valid idle", 32'(o_blk_valid), 32'h0);
        mode_now = (nxt_mode == shcg_pkg::MODE_FEC) ? shcg_pkg::MODE_FEC : shcg_pkg::MODE_CRC12;
        emb_idx = (emb_idx + 1) % e;
        mbn++;
    endtask

    initial begin
        repeat (6) @(posedge i_mclk);
        #1;
        check("rst header", 32'(o_sync_header), 32'(shcg_pkg::SH_ZERO));
        check("rst valid", 32'(o_blk_valid), 32'h0);
        check("rst stream", o_stream_word, 32'h0);
        i_rst_n = 1'b1;
        // first multiblock carries zero parity, single-bit data gives the poly
        run_mb(shcg_pkg::MODE_FEC, 1, 0, 0);
        check_mb(1, 12'h000, 26'h0000000);
        run_mb(shcg_pkg::MODE_CRC12, 1, 0, 0);
        check_mb(1, 12'h000, shcg_pkg::FEC_POLY);
        run_mb(shcg_pkg::MODE_CRC3, 2, 0, 1);
        check_mb(1, shcg_pkg::CRC_POLY, 26'h0000000);
        run_mb(2'h3, 2, 0, 0);
        check_mb(0, 12'h000, 26'h0000000);
        run_mb(shcg_pkg::MODE_FEC, 2, 0, 0);
        check_mb(0, 12'h000, 26'h0000000);
        run_mb(shcg_pkg::MODE_CRC12, 0, 0, 0);
        check_mb(0, 12'h000, 26'h0000000);
        // restart of the extended multiblock with a length of one
        i_emb_len = 8'h01;
        run_mb(shcg_pkg::MODE_CRC12, 2, 1, 0);
        check_mb(0, 12'h000, 26'h0000000);
        i_emb_len = 8'h00;
        run_mb(shcg_pkg::MODE_CRC12, 2, 0, 0);
        check_mb(0, 12'h000, 26'h0000000);
        summarize();
    end
endmodule
`default_nettype wire
